// ---- core/dacr_defs.vh ----
// register map, field positions, reset values and pattern words of the converter config bank
`ifndef DACR_DEFS_VH
`define DACR_DEFS_VH

`define DACR_ADDR_CHAN_SEL 8'h05
`define DACR_ADDR_POWER 8'h08
`define DACR_ADDR_CLOCK 8'h09
`define DACR_ADDR_PATTERN 8'h0D
`define DACR_ADDR_SELF_CHECK 8'h0E
`define DACR_ADDR_INPUT 8'h0F
`define DACR_ADDR_TRIM 8'h10
`define DACR_ADDR_FORMAT 8'h14
`define DACR_ADDR_PHASE 8'h16
`define DACR_ADDR_REF 8'h18
`define DACR_ADDR_SIG_LO 8'h24
`define DACR_ADDR_SIG_HI 8'h25
`define DACR_ADDR_XFER 8'hFF

`define DACR_RST_CHAN_SEL 8'hFF
`define DACR_RST_POWER 8'h00
`define DACR_RST_CLOCK 8'h01
`define DACR_RST_PATTERN 8'h00
`define DACR_RST_SELF_CHECK 8'h00
`define DACR_RST_INPUT 8'h00
`define DACR_RST_TRIM 8'h00
`define DACR_RST_FORMAT 8'h00
`define DACR_RST_PHASE 8'h00
`define DACR_RST_REF 8'h00
`define DACR_RST_SIG 16'h0000
`define DACR_RST_XFER 8'hFF
`define DACR_XFER_CMD 8'h01
`define DACR_READ_UNMAPPED 8'h00

// field positions
`define DACR_SEL_A 0
`define DACR_SEL_B 1
`define DACR_XFER_BIT 0
`define DACR_PD_LSB 0
`define DACR_PD_MSB 1
`define DACR_CLK_DCS 0
`define DACR_CLK_BOOST 1
`define DACR_PAT_MODE_LSB 0
`define DACR_PAT_MODE_MSB 2
`define DACR_PAT_RST_SHORT 4
`define DACR_PAT_RST_LONG 5
`define DACR_CHK_EN 0
`define DACR_CHK_INIT 2
`define DACR_IN_CM_EN 1
`define DACR_IN_DISC 2
`define DACR_TRIM_MSB 3
`define DACR_FMT_LSB 0
`define DACR_FMT_MSB 1
`define DACR_FMT_INVERT 2
`define DACR_FMT_DISABLE 4
`define DACR_PHASE_INV 7
`define DACR_REF_MSB 4

// pattern codes
`define DACR_PM_OFF 3'b000
`define DACR_PM_MID 3'b001
`define DACR_PM_POS_FS 3'b010
`define DACR_PM_NEG_FS 3'b011
`define DACR_PM_CHECKER 3'b100
`define DACR_PM_LONG 3'b101
`define DACR_PM_SHORT 3'b110
`define DACR_PM_TOGGLE 3'b111

// output format codes
`define DACR_FMT_OFFSET_BIN 2'b00
`define DACR_FMT_TWOS 2'b01
`define DACR_FMT_GRAY 2'b10

// pattern words and generator seeds
`define DACR_WORD_MID 8'h80
`define DACR_WORD_POS_FS 8'hFF
`define DACR_WORD_NEG_FS 8'h00
`define DACR_WORD_CHECK0 8'hAA
`define DACR_WORD_CHECK1 8'h55
`define DACR_WORD_ONES 8'hFF
`define DACR_WORD_ZEROS 8'h00
`define DACR_LONG_SEED 23'h7FFFFF
`define DACR_SHORT_SEED 9'h1FF
`define DACR_LONG_TAP 18
`define DACR_SHORT_TAP 5

`endif

// ---- core/dacr_patgen.v ----
// per-channel output test pattern generator
`default_nettype none

module dacr_patgen
(
	input wire clk,
	input wire rst,
	input wire [2:0] mode,
	input wire long_reset,
	input wire short_reset,
	output reg [7:0] pattern_r
);
`include "dacr_defs.vh"

	reg [22:0] long_r;
	reg [8:0] short_r;
	reg phase_r;
	reg [7:0] pattern_nxt;
	reg [22:0] long_nxt;
	reg [8:0] short_nxt;
	integer i;

	// eight serial steps per sample, so each long word carries eight fresh sequence bits, each short word seven
	always @*
	begin
		long_nxt = long_r;
		short_nxt = short_r;
		for (i = 0; i < 8; i = i + 1)
		begin
			long_nxt = {long_nxt[21:0], long_nxt[22] ^ long_nxt[`DACR_LONG_TAP - 1]};
			short_nxt = {short_nxt[7:0], short_nxt[8] ^ short_nxt[`DACR_SHORT_TAP - 1]};
		end
	end

	always @*
	begin
		case (mode)
			`DACR_PM_MID: pattern_nxt = `DACR_WORD_MID;
			`DACR_PM_POS_FS: pattern_nxt = `DACR_WORD_POS_FS;
			`DACR_PM_NEG_FS: pattern_nxt = `DACR_WORD_NEG_FS;
			`DACR_PM_CHECKER: pattern_nxt = phase_r ? `DACR_WORD_CHECK1 : `DACR_WORD_CHECK0;
			`DACR_PM_LONG: pattern_nxt = long_r[22:15];
			`DACR_PM_SHORT: pattern_nxt = {short_r[8:2], short_r[0]};
			`DACR_PM_TOGGLE: pattern_nxt = phase_r ? `DACR_WORD_ZEROS : `DACR_WORD_ONES;
			default: pattern_nxt = 8'h00;
		endcase
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			long_r <= `DACR_LONG_SEED;
			short_r <= `DACR_SHORT_SEED;
			phase_r <= 1'b0;
			pattern_r <= 8'h00;
		end
		else
		begin
			phase_r <= ~phase_r;
			pattern_r <= pattern_nxt;
			// generators held at seed while their reset bit stands
			long_r <= long_reset ? `DACR_LONG_SEED : long_nxt;
			short_r <= short_reset ? `DACR_SHORT_SEED : short_nxt;
		end
	end

endmodule // dacr_patgen

`default_nettype wire

// ---- core/dacr_regs.v ----
// configuration register bank and output datapath of the dual 8-bit converter
// Summary of operation
// - index register picks channels for next write; resets to 0xFF, all channels.
// - index bit 0 selects A, bit 1 B; both set writes both channels.
// - read with both index bits set returns the channel A copy.
// - program writes act only after 0x01 to transfer; all update; bit self-clears.
// - test mode 000 disables patterns, 001 drives constant midscale word.
// - test mode 010 drives positive full scale, 011 negative full scale.
// - test mode 100 checkerboard, 101 long pseudorandom sequence.
// - test mode 110 short pseudorandom sequence, 111 all-ones/all-zeros toggle.
// - separate test-mode bits reset long and short generators to seed.
// - offset trim is four-bit two's complement, +7 to -8, zero no change.
// - reference register scales reference and full scale; reset selects nominal.
// - signature low byte per channel is read-only, resets to zero.
// - signature high byte per channel is read-only, resets to zero.
`default_nettype none

module dacr_regs
(
	input wire REF_CLK,
	input wire RST,
	input wire REG_WR,
	input wire REG_RD,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	output reg [7:0] REG_RDATA,
	output reg REG_RVALID,
	input wire [7:0] SAMPLE_A,
	input wire [7:0] SAMPLE_B,
	output reg [7:0] DATA_A,
	output reg [7:0] DATA_B,
	output reg OUT_EN_A,
	output reg OUT_EN_B,
	output reg [1:0] POWER_DOWN,
	output reg DUTY_STAB_EN,
	output reg CLOCK_BOOST,
	output reg CM_INPUT_EN,
	output reg ANALOG_DISC_A,
	output reg ANALOG_DISC_B,
	output reg OUTPUT_DATA_CLOCK_INV,
	output reg [4:0] REF_SCALE
);
`include "dacr_defs.vh"

	// master copies written by the host
	reg [7:0] chan_sel_r;
	reg [7:0] xfer_r;
	reg [7:0] m_power_r, m_clock_r, m_phase_r, m_ref_r, m_cm_r;
	reg [7:0] m_pat_a_r, m_pat_b_r, m_chk_a_r, m_chk_b_r, m_in_a_r, m_in_b_r;
	reg [7:0] m_trim_a_r, m_trim_b_r, m_fmt_a_r, m_fmt_b_r;
	// active copies that steer the part
	reg [7:0] a_pat_a_r, a_pat_b_r, a_chk_a_r, a_chk_b_r;
	reg [7:0] a_trim_a_r, a_trim_b_r, a_fmt_a_r, a_fmt_b_r;
	reg [15:0] sig_a_r, sig_b_r;
	reg [7:0] rdata_nxt;
	wire wr_a, wr_b, xfer_go, rd_b;
	wire [7:0] pat_a, pat_b;
	// reset word picked apart by field, so each option flop gets only its own bit
	localparam [7:0] clock_reset_word = `DACR_RST_CLOCK;

	assign wr_a = REG_WR & chan_sel_r[`DACR_SEL_A];
	assign wr_b = REG_WR & chan_sel_r[`DACR_SEL_B];
	// reads go to B only when A is not also selected
	assign rd_b = chan_sel_r[`DACR_SEL_B] & ~chan_sel_r[`DACR_SEL_A];
	assign xfer_go = xfer_r[`DACR_XFER_BIT];

	// trim, format, invert of one sample; saturates rather than wrapping at the rails
	function [7:0] shape;
		input [7:0] s;
		input [7:0] trim;
		input [7:0] fmt;
		reg [9:0] sum;
		reg [7:0] v;
		begin
			sum = {2'b00, s} + {{6{trim[`DACR_TRIM_MSB]}}, trim[3:0]};
			if (sum[9])
				v = 8'h00;
			else if (sum[8])
				v = 8'hFF;
			else
				v = sum[7:0];
			case (fmt[`DACR_FMT_MSB:`DACR_FMT_LSB])
				`DACR_FMT_TWOS: v = {~v[7], v[6:0]};
				`DACR_FMT_GRAY: v = v ^ {1'b0, v[7:1]};
				default: v = v;
			endcase
			shape = fmt[`DACR_FMT_INVERT] ? ~v : v;
		end
	endfunction

	// one signature step; polynomial x^16+x^12+x^5+1 folded with the output word
	function [15:0] sig_step;
		input [15:0] sig;
		input [7:0] d;
		begin
			sig_step = {sig[14:0], sig[15] ^ sig[11] ^ sig[4]} ^ {8'h00, d};
		end
	endfunction

	dacr_patgen u_pat_a
	(
		.clk(REF_CLK),
		.rst(RST),
		.mode(a_pat_a_r[`DACR_PAT_MODE_MSB:`DACR_PAT_MODE_LSB]),
		.long_reset(a_pat_a_r[`DACR_PAT_RST_LONG]),
		.short_reset(a_pat_a_r[`DACR_PAT_RST_SHORT]),
		.pattern_r(pat_a)
	);

	dacr_patgen u_pat_b
	(
		.clk(REF_CLK),
		.rst(RST),
		.mode(a_pat_b_r[`DACR_PAT_MODE_MSB:`DACR_PAT_MODE_LSB]),
		.long_reset(a_pat_b_r[`DACR_PAT_RST_LONG]),
		.short_reset(a_pat_b_r[`DACR_PAT_RST_SHORT]),
		.pattern_r(pat_b)
	);

	// host writes into index, transfer and master copies
	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			chan_sel_r <= `DACR_RST_CHAN_SEL;
			xfer_r <= `DACR_RST_XFER;
			m_power_r <= `DACR_RST_POWER;
			m_clock_r <= `DACR_RST_CLOCK;
			m_phase_r <= `DACR_RST_PHASE;
			m_ref_r <= `DACR_RST_REF;
			m_cm_r <= `DACR_RST_INPUT;
			m_pat_a_r <= `DACR_RST_PATTERN;
			m_pat_b_r <= `DACR_RST_PATTERN;
			m_chk_a_r <= `DACR_RST_SELF_CHECK;
			m_chk_b_r <= `DACR_RST_SELF_CHECK;
			m_in_a_r <= `DACR_RST_INPUT;
			m_in_b_r <= `DACR_RST_INPUT;
			m_trim_a_r <= `DACR_RST_TRIM;
			m_trim_b_r <= `DACR_RST_TRIM;
			m_fmt_a_r <= `DACR_RST_FORMAT;
			m_fmt_b_r <= `DACR_RST_FORMAT;
		end
		else
		begin
			// transfer bit lasts one cycle; a fresh write in that cycle wins
			if (REG_WR && REG_ADDR == `DACR_ADDR_XFER)
				xfer_r <= REG_WDATA;
			else
				xfer_r <= {xfer_r[7:1], 1'b0};
			if (REG_WR)
			begin
				case (REG_ADDR)
					`DACR_ADDR_CHAN_SEL: chan_sel_r <= REG_WDATA;
					`DACR_ADDR_POWER: m_power_r <= REG_WDATA;
					`DACR_ADDR_CLOCK: m_clock_r <= REG_WDATA;
					`DACR_ADDR_PHASE: m_phase_r <= REG_WDATA;
					`DACR_ADDR_REF: m_ref_r <= REG_WDATA;
					`DACR_ADDR_INPUT: m_cm_r <= REG_WDATA;
					default: m_power_r <= m_power_r;
				endcase
			end
			if (wr_a)
			begin
				case (REG_ADDR)
					`DACR_ADDR_PATTERN: m_pat_a_r <= REG_WDATA;
					`DACR_ADDR_SELF_CHECK: m_chk_a_r <= REG_WDATA;
					`DACR_ADDR_INPUT: m_in_a_r <= REG_WDATA;
					`DACR_ADDR_TRIM: m_trim_a_r <= REG_WDATA;
					`DACR_ADDR_FORMAT: m_fmt_a_r <= REG_WDATA;
					default: m_pat_a_r <= m_pat_a_r;
				endcase
			end
			if (wr_b)
			begin
				case (REG_ADDR)
					`DACR_ADDR_PATTERN: m_pat_b_r <= REG_WDATA;
					`DACR_ADDR_SELF_CHECK: m_chk_b_r <= REG_WDATA;
					`DACR_ADDR_INPUT: m_in_b_r <= REG_WDATA;
					`DACR_ADDR_TRIM: m_trim_b_r <= REG_WDATA;
					`DACR_ADDR_FORMAT: m_fmt_b_r <= REG_WDATA;
					default: m_pat_b_r <= m_pat_b_r;
				endcase
			end
		end
	end

	// active copies load together, only on the transfer pulse
	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			a_pat_a_r <= `DACR_RST_PATTERN;
			a_pat_b_r <= `DACR_RST_PATTERN;
			a_chk_a_r <= `DACR_RST_SELF_CHECK;
			a_chk_b_r <= `DACR_RST_SELF_CHECK;
			a_trim_a_r <= `DACR_RST_TRIM;
			a_trim_b_r <= `DACR_RST_TRIM;
			a_fmt_a_r <= `DACR_RST_FORMAT;
			a_fmt_b_r <= `DACR_RST_FORMAT;
			POWER_DOWN <= 2'b00;
			DUTY_STAB_EN <= clock_reset_word[`DACR_CLK_DCS];
			CLOCK_BOOST <= clock_reset_word[`DACR_CLK_BOOST];
			CM_INPUT_EN <= 1'b0;
			ANALOG_DISC_A <= 1'b0;
			ANALOG_DISC_B <= 1'b0;
			OUTPUT_DATA_CLOCK_INV <= 1'b0;
			REF_SCALE <= 5'h00;
		end
		else if (xfer_go)
		begin
			a_pat_a_r <= m_pat_a_r;
			a_pat_b_r <= m_pat_b_r;
			a_chk_a_r <= m_chk_a_r;
			a_chk_b_r <= m_chk_b_r;
			a_trim_a_r <= m_trim_a_r;
			a_trim_b_r <= m_trim_b_r;
			a_fmt_a_r <= m_fmt_a_r;
			a_fmt_b_r <= m_fmt_b_r;
			// reserved codes pass through unchanged; software must not use them
			POWER_DOWN <= m_power_r[`DACR_PD_MSB:`DACR_PD_LSB];
			DUTY_STAB_EN <= m_clock_r[`DACR_CLK_DCS];
			CLOCK_BOOST <= m_clock_r[`DACR_CLK_BOOST];
			CM_INPUT_EN <= m_cm_r[`DACR_IN_CM_EN];
			ANALOG_DISC_A <= m_in_a_r[`DACR_IN_DISC];
			ANALOG_DISC_B <= m_in_b_r[`DACR_IN_DISC];
			OUTPUT_DATA_CLOCK_INV <= m_phase_r[`DACR_PHASE_INV];
			REF_SCALE <= m_ref_r[`DACR_REF_MSB:0];
		end
	end

	// output datapath and signature registers
	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			DATA_A <= 8'h00;
			DATA_B <= 8'h00;
			OUT_EN_A <= 1'b1;
			OUT_EN_B <= 1'b1;
			sig_a_r <= `DACR_RST_SIG;
			sig_b_r <= `DACR_RST_SIG;
		end
		else
		begin
			OUT_EN_A <= ~a_fmt_a_r[`DACR_FMT_DISABLE];
			OUT_EN_B <= ~a_fmt_b_r[`DACR_FMT_DISABLE];
			if (a_pat_a_r[`DACR_PAT_MODE_MSB:`DACR_PAT_MODE_LSB] != `DACR_PM_OFF)
				DATA_A <= pat_a;
			else
				DATA_A <= shape(SAMPLE_A, a_trim_a_r, a_fmt_a_r);
			if (a_pat_b_r[`DACR_PAT_MODE_MSB:`DACR_PAT_MODE_LSB] != `DACR_PM_OFF)
				DATA_B <= pat_b;
			else
				DATA_B <= shape(SAMPLE_B, a_trim_b_r, a_fmt_b_r);
			// init holds the signature at zero; enable folds each output word in
			if (a_chk_a_r[`DACR_CHK_INIT])
				sig_a_r <= `DACR_RST_SIG;
			else if (a_chk_a_r[`DACR_CHK_EN])
				sig_a_r <= sig_step(sig_a_r, DATA_A);
			if (a_chk_b_r[`DACR_CHK_INIT])
				sig_b_r <= `DACR_RST_SIG;
			else if (a_chk_b_r[`DACR_CHK_EN])
				sig_b_r <= sig_step(sig_b_r, DATA_B);
		end
	end

	// read mux returns master copies, signatures are read-only
	always @*
	begin
		case (REG_ADDR)
			`DACR_ADDR_CHAN_SEL: rdata_nxt = chan_sel_r;
			`DACR_ADDR_XFER: rdata_nxt = xfer_r;
			`DACR_ADDR_POWER: rdata_nxt = m_power_r;
			`DACR_ADDR_CLOCK: rdata_nxt = m_clock_r;
			`DACR_ADDR_PHASE: rdata_nxt = m_phase_r;
			`DACR_ADDR_REF: rdata_nxt = m_ref_r;
			`DACR_ADDR_PATTERN: rdata_nxt = rd_b ? m_pat_b_r : m_pat_a_r;
			`DACR_ADDR_SELF_CHECK: rdata_nxt = rd_b ? m_chk_b_r : m_chk_a_r;
			`DACR_ADDR_INPUT: rdata_nxt = (rd_b ? m_in_b_r : m_in_a_r) | (m_cm_r & 8'h02);
			`DACR_ADDR_TRIM: rdata_nxt = rd_b ? m_trim_b_r : m_trim_a_r;
			`DACR_ADDR_FORMAT: rdata_nxt = rd_b ? m_fmt_b_r : m_fmt_a_r;
			`DACR_ADDR_SIG_LO: rdata_nxt = rd_b ? sig_b_r[7:0] : sig_a_r[7:0];
			`DACR_ADDR_SIG_HI: rdata_nxt = rd_b ? sig_b_r[15:8] : sig_a_r[15:8];
			default: rdata_nxt = `DACR_READ_UNMAPPED;
		endcase
	end

	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			REG_RDATA <= 8'h00;
			REG_RVALID <= 1'b0;
		end
		else
		begin
			REG_RVALID <= REG_RD;
			if (REG_RD)
				REG_RDATA <= rdata_nxt;
		end
	end

endmodule // dacr_regs

`default_nettype wire

// ---- testbench/dacr_checker_assertions.sv ----
// assertion checker for the converter config bank
`default_nettype none
module dacr_checker
(
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic REG_RVALID,
	input wire logic [1:0] POWER_DOWN,
	input wire logic [4:0] REF_SCALE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);
	logic [7:0] idx_r;
	logic [7:0] pd_r;
	logic [7:0] ref_r;
	logic [2:0] age_r;
	wire logic xfer = REG_WR && REG_ADDR == 8'hFF && REG_WDATA[0];
	// master copies, and cycles since the last transfer (saturates at 7)
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			idx_r <= 8'hFF;
			pd_r <= 8'h00;
			ref_r <= 8'h00;
			age_r <= 3'h7;
		end
		else
		begin
			if (REG_WR && REG_ADDR == 8'h05)
				idx_r <= REG_WDATA;
			if (REG_WR && REG_ADDR == 8'h08)
				pd_r <= REG_WDATA;
			if (REG_WR && REG_ADDR == 8'h18)
				ref_r <= REG_WDATA;
			if (xfer)
				age_r <= 3'h0;
			else if (age_r != 3'h7)
				age_r <= age_r + 3'h1;
		end
	end
	property p_rvalid;
		REG_RD |=> REG_RVALID;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_no_rvalid;
		!REG_RD |=> !REG_RVALID;
	endproperty
	a_no_rvalid: assert property (p_no_rvalid) else $error("stray read answer");
	property p_rdata_hold;
		!REG_RD |=> $stable(REG_RDATA);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_idx_read;
		REG_RD && REG_ADDR == 8'h05 |=> REG_RDATA == $past(idx_r);
	endproperty
	a_idx_read: assert property (p_idx_read) else $error("index readback wrong");
	property p_pd_read;
		REG_RD && REG_ADDR == 8'h08 |=> REG_RDATA[1:0] == $past(pd_r[1:0]);
	endproperty
	a_pd_read: assert property (p_pd_read) else $error("power readback wrong");
	property p_pd_shadow;
		$changed(POWER_DOWN) |-> age_r < 3'h4;
	endproperty
	a_pd_shadow: assert property (p_pd_shadow) else $error("power moved early");
	property p_ref_shadow;
		$changed(REF_SCALE) |-> age_r < 3'h4;
	endproperty
	a_ref_shadow: assert property (p_ref_shadow) else $error("ref moved early");
	property p_pd_apply;
		xfer |-> ##3 POWER_DOWN == pd_r[1:0];
	endproperty
	a_pd_apply: assert property (p_pd_apply) else $error("power not applied");
	property p_ref_apply;
		xfer |-> ##3 REF_SCALE == ref_r[4:0];
	endproperty
	a_ref_apply: assert property (p_ref_apply) else $error("ref not applied");
endmodule // dacr_checker
bind dacr_regs dacr_checker u_chk (.REF_CLK(REF_CLK), .RST(RST), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.REG_RVALID(REG_RVALID), .POWER_DOWN(POWER_DOWN), .REF_SCALE(REF_SCALE));
`default_nettype wire

// ---- testbench/dacr_host.sv ----
// host model issuing register strobes to the config bank
`default_nettype none
module dacr_host
(
	input wire logic clk,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	output var logic wr = 1'b0,
	output var logic rd = 1'b0,
	output var logic [7:0] addr = 8'h00,
	output var logic [7:0] wdata = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle lines show the inverse so a stale value is never mistaken for a live one
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask
	task automatic get(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~a;
		#1;
		d = rdata;
		v = rvalid;
	endtask
	task automatic sel(input logic [7:0] m);
		put(8'h05, m);
	endtask
	task automatic xfer;
		put(8'hFF, 8'h01);
	endtask
endmodule // dacr_host
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the converter config bank
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic wr, rd, rv, oea, oeb, dse, cbo, cm, dia, dib, inv;
	logic [7:0] addr, wd, rdat, da, db;
	logic [7:0] sa = 8'h40;
	logic [7:0] sb = 8'h40;
	logic [1:0] pd;
	logic [4:0] rs;
	int error_cnt = 0;
	int checked = 0;
	localparam logic [7:0] RA [13] = '{8'h05, 8'h08, 8'h09, 8'h0D, 8'h0E, 8'h0F, 8'h10,
		8'h14, 8'h16, 8'h18, 8'h24, 8'h25, 8'hFF};
	localparam logic [7:0] RV [13] = '{8'hFF, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFE};
	// transfer resets to 0xFF but its bit 0 has cleared itself before the first read
	localparam logic [7:0] PW [3] = '{8'h80, 8'hFF, 8'h00};
	always #5 ref_clk = ~ref_clk;
	dacr_host u_host (.clk(ref_clk), .rdata(rdat), .rvalid(rv), .wr(wr), .rd(rd),
		.addr(addr), .wdata(wd));
	dacr_regs u_dut (.REF_CLK(ref_clk), .RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
		.REG_WDATA(wd), .REG_RDATA(rdat), .REG_RVALID(rv), .SAMPLE_A(sa), .SAMPLE_B(sb),
		.DATA_A(da), .DATA_B(db), .OUT_EN_A(oea), .OUT_EN_B(oeb), .POWER_DOWN(pd),
		.DUTY_STAB_EN(dse), .CLOCK_BOOST(cbo), .CM_INPUT_EN(cm), .ANALOG_DISC_A(dia),
		.ANALOG_DISC_B(dib), .OUTPUT_DATA_CLOCK_INV(inv), .REF_SCALE(rs));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		u_host.get(a, d, v);
		chk({7'h00, v}, 8'h01);
		chk(d, e);
	endtask
	task automatic setmode(input logic [7:0] m);
		u_host.put(8'h0D, m);
		u_host.xfer();
		cyc(5);
	endtask
	task automatic pair(input logic [7:0] e);
		logic [7:0] d;
		d = da;
		cyc(1);
		chk(d ^ da, 8'hFF);
		chk((d === e || d === ~e) ? 8'h01 : 8'h00, 8'h01);
	endtask
	task automatic t_reset;
		for (int i = 0; i < 13; i++)
			rdchk(RA[i], RV[i]);
		rdchk(8'h30, 8'h00);
		chk({6'h00, pd}, 8'h00);
		chk({3'h0, rs}, 8'h00);
	endtask
	task automatic t_ro;
		u_host.put(8'h24, 8'h5A);
		u_host.put(8'h25, 8'hA5);
		rdchk(8'h24, 8'h00);
		rdchk(8'h25, 8'h00);
	endtask
	task automatic t_shadow;
		u_host.put(8'h08, 8'h01);
		u_host.put(8'h18, 8'h13);
		cyc(3);
		chk({6'h00, pd}, 8'h00);
		rdchk(8'h08, 8'h01);
		u_host.xfer();
		cyc(3);
		chk({6'h00, pd}, 8'h01);
		chk({3'h0, rs}, 8'h13);
		rdchk(8'hFF, 8'h00);
		u_host.put(8'h08, 8'h00);
		u_host.xfer();
	endtask
	task automatic t_local;
		u_host.sel(8'h01);
		u_host.put(8'h10, 8'h07);
		u_host.sel(8'h02);
		u_host.put(8'h10, 8'h08);
		rdchk(8'h10, 8'h08);
		u_host.sel(8'h01);
		rdchk(8'h10, 8'h07);
		u_host.sel(8'h03);
		rdchk(8'h10, 8'h07);
		u_host.xfer();
		cyc(4);
		chk(da, 8'h47);
		chk(db, 8'h38);
		u_host.put(8'h10, 8'h00);
		u_host.xfer();
		cyc(4);
		chk(da, 8'h40);
		chk(db, 8'h40);
	endtask
	task automatic t_pattern;
		logic [7:0] d;
		logic moved;
		for (int m = 1; m < 4; m++)
		begin
			setmode(8'(m));
			chk(da, PW[m-1]);
			chk(db, PW[m-1]);
		end
		setmode(8'h04);
		pair(8'hAA);
		setmode(8'h07);
		pair(8'hFF);
		for (int k = 0; k < 2; k++)
		begin
			setmode(k ? 8'h16 : 8'h25);
			d = da;
			cyc(2);
			chk(da, d);
			chk(d, 8'hFF);
			setmode(k ? 8'h06 : 8'h05);
			moved = 1'b0;
			repeat (6)
			begin
				cyc(1);
				if (da !== d)
					moved = 1'b1;
			end
			chk({7'h00, moved}, 8'h01);
		end
		u_host.sel(8'h02);
		setmode(8'h00);
		u_host.sel(8'h01);
		setmode(8'h02);
		chk(da, 8'hFF);
		chk(db, 8'h40);
	endtask
	task automatic t_misc;
		logic [7:0] lo, hi;
		logic v;
		u_host.sel(8'h03);
		u_host.put(8'h0D, 8'h00);
		u_host.put(8'h09, 8'h02);
		u_host.put(8'h16, 8'h80);
		u_host.sel(8'h01);
		u_host.put(8'h0F, 8'h06);
		u_host.put(8'h14, 8'h01);
		u_host.sel(8'h02);
		u_host.put(8'h0F, 8'h02);
		u_host.put(8'h14, 8'h16);
		@(posedge ref_clk);
		sa <= 8'hC3;
		sb <= 8'hC3;
		cyc(3);
		// nothing written above may act before the transfer
		chk({2'h0, inv, dia, dib, cm, cbo, dse}, 8'h01);
		chk(da, 8'hFF);
		chk(db, 8'hC3);
		u_host.xfer();
		cyc(4);
		chk({2'h0, inv, dia, dib, cm, cbo, dse}, 8'h36);
		chk({6'h00, oea, oeb}, 8'h02);
		// twos complement on A; gray, inverted and disabled on B
		chk(da, 8'h43);
		chk(db, 8'h5D);
		u_host.sel(8'h01);
		u_host.put(8'h0E, 8'h01);
		u_host.xfer();
		cyc(8);
		u_host.put(8'h0E, 8'h00);
		u_host.xfer();
		cyc(3);
		u_host.get(8'h24, lo, v);
		u_host.get(8'h25, hi, v);
		chk(({hi, lo} != 16'h0000) ? 8'h01 : 8'h00, 8'h01);
		u_host.sel(8'h02);
		rdchk(8'h24, 8'h00);
		rdchk(8'h25, 8'h00);
		u_host.sel(8'h01);
		u_host.put(8'h0E, 8'h04);
		u_host.xfer();
		cyc(3);
		rdchk(8'h24, 8'h00);
		rdchk(8'h25, 8'h00);
		// +7 on a near-rail sample must clip, not wrap
		u_host.put(8'h10, 8'h07);
		u_host.put(8'h14, 8'h00);
		@(posedge ref_clk);
		sa <= 8'hFE;
		u_host.xfer();
		cyc(4);
		chk(da, 8'hFF);
	endtask
	task automatic end_of_test;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_ro();
		t_shadow();
		t_local();
		t_pattern();
		t_misc();
		end_of_test();
	end
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		error_cnt++;
		end_of_test();
	end
endmodule // tb
`default_nettype wire
